// *** hdl/hsgr_pkg.sv ***
// Report codes, field positions and layout constants for the HID status/GPIO reports
package hsgr_pkg;

  // ----------------------------------------------------------------
  // Report identifiers
  // ----------------------------------------------------------------
  localparam logic [7:0] ID_UART_STATUS = 8'h42;
  localparam logic [7:0] ID_FIFO_FLUSH  = 8'h43;
  localparam logic [7:0] ID_PIN_GET     = 8'h44;
  localparam logic [7:0] ID_PIN_SET     = 8'h45;

  // ----------------------------------------------------------------
  // Report lengths in bytes
  // ----------------------------------------------------------------
  localparam logic [2:0] LEN_UART_STATUS = 3'h7;
  localparam logic [2:0] LEN_FIFO_FLUSH  = 3'h2;
  localparam logic [2:0] LEN_PIN_GET     = 3'h3;
  localparam logic [2:0] LEN_PIN_SET     = 3'h5;
  localparam int         MAX_REP_BYTES   = 7;

  // ----------------------------------------------------------------
  // FIFO fill counts (0 .. 512)
  // ----------------------------------------------------------------
  localparam int         FILL_W      = 10;
  localparam logic [9:0] FIFO_BYTES  = 10'h200;

  // ----------------------------------------------------------------
  // Error byte bits and break byte values
  // ----------------------------------------------------------------
  localparam int         ERR_PARITY  = 0;
  localparam int         ERR_OVERRUN = 1;
  localparam int         ERR_FRAMING = 2;
  localparam int         ERR_BREAK   = 3;
  localparam int         ERR_W       = 4;
  localparam logic [7:0] BRK_IDLE    = 8'h00;
  localparam logic [7:0] BRK_ACTIVE  = 8'h01;

  // ----------------------------------------------------------------
  // Flush selection bits
  // ----------------------------------------------------------------
  localparam int FLUSH_TX = 0;
  localparam int FLUSH_RX = 1;

  // ----------------------------------------------------------------
  // Pin-level word layout
  // ----------------------------------------------------------------
  localparam int          PIN_GP0      = 0;  // General pins 0..3 at bits 0..3
  localparam int          PIN_TX       = 4;
  localparam int          PIN_RX       = 5;
  localparam int          PIN_GP4      = 6;  // General pins 4..5 at bits 6..7
  localparam int          PIN_USB_TWO  = 8;
  localparam int          PIN_GP6      = 10; // General pins 6..9 at bits 10..13
  localparam int          PIN_USB_ONE  = 14;
  localparam logic [15:0] PIN_VALID    = 16'h7dff; // Bits 9 and 15 reserved
  localparam logic [15:0] PIN_RESET    = 16'h0000;

endpackage

// *** hdl/hsgr_flag_if.sv ***
// Carrier between the report engine and the sticky error flag store
`timescale 1ns/1ps
`default_nettype none
interface hsgr_flag_if;
  logic [3:0] event_set;  // Receive error / break events this cycle
  logic       read_clear; // Status report snapshot taken this cycle
  logic [3:0] flags;      // Latched flags

  modport engine (output event_set, output read_clear, input flags);
  modport store  (input event_set, input read_clear, output flags);
endinterface
`default_nettype wire

// *** hdl/hsgr_flags.sv ***
// Sticky receive error and break flags with read-clear
`timescale 1ns/1ps
`default_nettype none
module hsgr_flags (
  // Clock and reset
  input  wire logic    clk_i,
  input  wire logic    rst_b_i,
  // Engine side
  hsgr_flag_if.store   fl
);

  logic [3:0] flags_q;
  logic [3:0] flags_d;

  // ----------------------------------------------------------------
  // Flag update
  // ----------------------------------------------------------------
  // set beats clear
  always_comb begin
    flags_d = fl.read_clear ? 4'h0 : flags_q;
    flags_d = flags_d | fl.event_set;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flags_q <= 4'h0;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign fl.flags = flags_q;

endmodule
`default_nettype wire

// *** hdl/hsgr_top.sv ***
// HID status, FIFO flush and pin-level report engine
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Status request answers seven bytes, first byte is the status report code.
// - Status bytes one and two carry transmit FIFO fill, upper byte first.
// - Status bytes three and four carry receive FIFO fill, upper byte first.
// - Each FIFO holds up to 512 bytes; counts range zero to 512.
// - Byte five: bit0 parity, bit1 overrun, bit2 framing, bit3 break seen.
// - Error and break flags stay latched until a status read clears them.
// - Byte six is 01 while line break is active, else 00.
// - Accept two-byte flush report; second byte selects FIFOs to flush.
// - Bit0 flushes transmit FIFO, bit1 receive FIFO; requests self-clear.
// - Pin query returns three bytes: sampled levels of all pins, upper first.
// - Pin word maps general, serial and USB state pins; bits 9, 15 reserved.
// - Accept five-byte pin update: state word then mask, each upper first.
// - Pin driven to state bit only if output and mask bit set.
module hsgr_top (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // Control-in request from the host side
  input  wire logic        in_req_i,
  input  wire logic [7:0]  in_id_i,
  output logic             in_busy_o,
  output logic             in_nak_o,
  // Control-in report byte stream
  output logic             in_valid_o,
  output logic [7:0]       in_data_o,
  output logic             in_last_o,
  input  wire logic        in_ready_i,
  // Control-out report byte stream, byte 0 is the report code
  input  wire logic        out_valid_i,
  input  wire logic [7:0]  out_data_i,
  input  wire logic        out_last_i,
  output logic             out_nak_o,
  // FIFO side
  input  wire logic [9:0]  tx_fill_i,
  input  wire logic [9:0]  rx_fill_i,
  output logic             tx_fifo_flush_request_o,
  output logic             rx_fifo_flush_request_o,
  // Receive path events and line state
  input  wire logic        parity_err_i,
  input  wire logic        overrun_err_i,
  input  wire logic        framing_err_i,
  input  wire logic        break_seen_i,
  input  wire logic        break_active_i,
  // Pin levels and drive
  input  wire logic [9:0]  gpio_level_i,
  input  wire logic        tx_pin_level_i,
  input  wire logic        rx_pin_level_i,
  input  wire logic        usb_state_pin_one_i,
  input  wire logic        usb_state_pin_two_i,
  input  wire logic [15:0] pin_is_output_i,
  output logic [15:0]      pin_drive_o
);

  typedef enum logic {HSGR_IDLE, HSGR_SEND} hsgr_state_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Join upper and lower bytes into a word
  function automatic logic [15:0] hsgr_word(input logic [7:0] hi, input logic [7:0] lo);
    hsgr_word = {hi, lo};
  endfunction

  // Widen a FIFO fill count to a 16-bit report field
  function automatic logic [15:0] hsgr_fill(input logic [9:0] cnt);
    hsgr_fill = {6'h00, cnt};
  endfunction

  // ----------------------------------------------------------------
  // Flag store
  // ----------------------------------------------------------------
  hsgr_flag_if fl ();

  hsgr_flags u_flags (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .fl      (fl.store)
  );

  always_comb begin
    fl.event_set                      = 4'h0;
    fl.event_set[hsgr_pkg::ERR_PARITY]  = parity_err_i;
    fl.event_set[hsgr_pkg::ERR_OVERRUN] = overrun_err_i;
    fl.event_set[hsgr_pkg::ERR_FRAMING] = framing_err_i;
    fl.event_set[hsgr_pkg::ERR_BREAK]   = break_seen_i;
  end

  // ----------------------------------------------------------------
  // Live pin word
  // ----------------------------------------------------------------
  logic [15:0] pin_word;

  always_comb begin
    pin_word                                 = 16'h0000;
    pin_word[hsgr_pkg::PIN_GP0 +: 4]         = gpio_level_i[3:0];
    pin_word[hsgr_pkg::PIN_TX]               = tx_pin_level_i;
    pin_word[hsgr_pkg::PIN_RX]               = rx_pin_level_i;
    pin_word[hsgr_pkg::PIN_GP4 +: 2]         = gpio_level_i[5:4];
    pin_word[hsgr_pkg::PIN_USB_TWO]          = usb_state_pin_two_i;
    pin_word[hsgr_pkg::PIN_GP6 +: 4]         = gpio_level_i[9:6];
    pin_word[hsgr_pkg::PIN_USB_ONE]          = usb_state_pin_one_i;
  end

  // ----------------------------------------------------------------
  // Control-in report engine
  // ----------------------------------------------------------------
  hsgr_state_t st_q;
  hsgr_state_t st_d;
  logic [7:0]  rep_q [hsgr_pkg::MAX_REP_BYTES];
  logic [7:0]  rep_d [hsgr_pkg::MAX_REP_BYTES];
  logic [2:0]  left_q;
  logic [2:0]  left_d;
  logic        in_nak_q;
  logic        in_nak_d;
  logic        take;
  logic [15:0] txw;
  logic [15:0] rxw;

  assign take = in_req_i && (st_q == HSGR_IDLE);
  assign txw  = hsgr_fill(tx_fill_i);
  assign rxw  = hsgr_fill(rx_fill_i);

  // Snapshot a report on request, then shift it out byte by byte
  always_comb begin
    st_d          = st_q;
    rep_d         = rep_q;
    left_d        = left_q;
    in_nak_d      = 1'b0;
    fl.read_clear = 1'b0;
    case (st_q)
      HSGR_IDLE: begin
        if (take) begin
          if (in_id_i == hsgr_pkg::ID_UART_STATUS) begin
            rep_d[0] = hsgr_pkg::ID_UART_STATUS;
            rep_d[1] = txw[15:8];
            rep_d[2] = txw[7:0];
            rep_d[3] = rxw[15:8];
            rep_d[4] = rxw[7:0];
            rep_d[5] = {4'h0, fl.flags};
            rep_d[6] = break_active_i ? hsgr_pkg::BRK_ACTIVE : hsgr_pkg::BRK_IDLE;
            fl.read_clear = 1'b1;
            left_d        = hsgr_pkg::LEN_UART_STATUS;
            st_d          = HSGR_SEND;
          end else if (in_id_i == hsgr_pkg::ID_PIN_GET) begin
            rep_d[0] = hsgr_pkg::ID_PIN_GET;
            rep_d[1] = pin_word[15:8];
            rep_d[2] = pin_word[7:0];
            left_d   = hsgr_pkg::LEN_PIN_GET;
            st_d     = HSGR_SEND;
          end else begin
            in_nak_d = 1'b1;
          end
        end
      end
      HSGR_SEND: begin
        if (in_ready_i) begin
          for (int i = 0; i < hsgr_pkg::MAX_REP_BYTES - 1; i++) begin
            rep_d[i] = rep_q[i + 1];
          end
          rep_d[hsgr_pkg::MAX_REP_BYTES - 1] = 8'h00;
          left_d = left_q - 3'h1;
          if (left_q == 3'h1) begin
            st_d = HSGR_IDLE;
          end
        end
      end
      default: begin
        st_d = HSGR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q     <= HSGR_IDLE;
      left_q   <= 3'h0;
      in_nak_q <= 1'b0;
      for (int i = 0; i < hsgr_pkg::MAX_REP_BYTES; i++) begin
        rep_q[i] <= 8'h00;
      end
    end else begin
      st_q     <= st_d;
      left_q   <= left_d;
      in_nak_q <= in_nak_d;
      rep_q    <= rep_d;
    end
  end

  assign in_busy_o  = (st_q != HSGR_IDLE);
  assign in_valid_o = (st_q == HSGR_SEND);
  assign in_data_o  = rep_q[0];
  assign in_last_o  = (st_q == HSGR_SEND) && (left_q == 3'h1);
  assign in_nak_o   = in_nak_q;

  // ----------------------------------------------------------------
  // Control-out report collector
  // ----------------------------------------------------------------
  logic [7:0]  obuf_q [hsgr_pkg::MAX_REP_BYTES];
  logic [7:0]  obuf_d [hsgr_pkg::MAX_REP_BYTES];
  logic [2:0]  ocnt_q;
  logic [2:0]  ocnt_d;
  logic        tx_fl_q;
  logic        tx_fl_d;
  logic        rx_fl_q;
  logic        rx_fl_d;
  logic        onak_q;
  logic        onak_d;
  logic [15:0] pin_q;
  logic [15:0] pin_d;
  logic [2:0]  olen;
  logic [15:0] set_word;
  logic [15:0] set_mask;

  // Gather bytes; act on the report when its last byte arrives
  always_comb begin
    obuf_d   = obuf_q;
    ocnt_d   = ocnt_q;
    tx_fl_d  = 1'b0;
    rx_fl_d  = 1'b0;
    onak_d   = 1'b0;
    pin_d    = pin_q;
    olen     = ocnt_q + 3'h1;
    set_word = 16'h0000;
    set_mask = 16'h0000;
    if (out_valid_i) begin
      if (ocnt_q < 3'(hsgr_pkg::MAX_REP_BYTES)) begin
        obuf_d[ocnt_q] = out_data_i;
        ocnt_d         = olen;
      end
      if (out_last_i) begin
        ocnt_d = 3'h0;
        if (obuf_d[0] == hsgr_pkg::ID_FIFO_FLUSH && olen == hsgr_pkg::LEN_FIFO_FLUSH) begin
          tx_fl_d = obuf_d[1][hsgr_pkg::FLUSH_TX];
          rx_fl_d = obuf_d[1][hsgr_pkg::FLUSH_RX];
        end else if (obuf_d[0] == hsgr_pkg::ID_PIN_SET && olen == hsgr_pkg::LEN_PIN_SET) begin
          set_word = hsgr_word(obuf_d[1], obuf_d[2]);
          set_mask = hsgr_word(obuf_d[3], obuf_d[4]) & pin_is_output_i & hsgr_pkg::PIN_VALID;
          pin_d = (pin_q & ~set_mask) | (set_word & set_mask);
        end else begin
          onak_d = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ocnt_q  <= 3'h0;
      tx_fl_q <= 1'b0;
      rx_fl_q <= 1'b0;
      onak_q  <= 1'b0;
      pin_q   <= hsgr_pkg::PIN_RESET;
      for (int i = 0; i < hsgr_pkg::MAX_REP_BYTES; i++) begin
        obuf_q[i] <= 8'h00;
      end
    end else begin
      ocnt_q  <= ocnt_d;
      tx_fl_q <= tx_fl_d;
      rx_fl_q <= rx_fl_d;
      onak_q  <= onak_d;
      pin_q   <= pin_d;
      obuf_q  <= obuf_d;
    end
  end

  // flush pulses are single registered strobes
  assign tx_fifo_flush_request_o = tx_fl_q;
  assign rx_fifo_flush_request_o = rx_fl_q;
  assign out_nak_o               = onak_q;
  assign pin_drive_o             = pin_q;

endmodule
`default_nettype wire

// *** dv/hsgr_assertions.sv ***
// Checker bound to the report engine ports
`timescale 1ns/1ps
`default_nettype none
module hsgr_checker (
  // Watched ports
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  input wire logic        in_req_i,
  input wire logic [7:0]  in_id_i,
  input wire logic        in_busy_o,
  input wire logic        in_nak_o,
  input wire logic        in_valid_o,
  input wire logic [7:0]  in_data_o,
  input wire logic        in_last_o,
  input wire logic        in_ready_i,
  input wire logic        out_valid_i,
  input wire logic        out_last_i,
  input wire logic        tx_fifo_flush_request_o,
  input wire logic        rx_fifo_flush_request_o,
  input wire logic [15:0] pin_drive_o
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic take;
  logic flush;
  // Request accepted and any flush strobe
  assign take = in_req_i && !in_busy_o;
  assign flush = tx_fifo_flush_request_o || rx_fifo_flush_request_o;
  stat_head_a: assert property (
    take && in_id_i == 8'h42 |=> in_busy_o && in_valid_o && in_data_o == 8'h42)
    else $error("status header wrong");
  pin_head_a: assert property (
    take && in_id_i == 8'h44 |=> in_busy_o && in_valid_o && in_data_o == 8'h44)
    else $error("pin query header wrong");
  bad_code_a: assert property (
    take && in_id_i != 8'h42 && in_id_i != 8'h44 |=> in_nak_o && !in_valid_o)
    else $error("unknown code not refused");
  byte_hold_a: assert property (
    in_valid_o && !in_ready_i |=> in_valid_o && $stable(in_data_o))
    else $error("report byte dropped");
  report_end_a: assert property (
    in_valid_o && in_ready_i && in_last_o |=> !in_busy_o && !in_valid_o)
    else $error("busy after last byte");
  flush_self_a: assert property (
    flush |=> !tx_fifo_flush_request_o && !rx_fifo_flush_request_o)
    else $error("flush request stuck");
  flush_cause_a: assert property (
    flush |-> $past(out_valid_i && out_last_i))
    else $error("flush without report");
  pin_cause_a: assert property (
    !$stable(pin_drive_o) |-> $past(out_valid_i && out_last_i))
    else $error("pin drive changed alone");
  rsvd_zero_a: assert property (
    pin_drive_o[9] == 1'b0 && pin_drive_o[15] == 1'b0)
    else $error("reserved pin driven");
endmodule
bind hsgr_top hsgr_checker chk_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .in_req_i(in_req_i),
  .in_id_i(in_id_i), .in_busy_o(in_busy_o), .in_nak_o(in_nak_o), .in_valid_o(in_valid_o),
  .in_data_o(in_data_o), .in_last_o(in_last_o), .in_ready_i(in_ready_i),
  .out_valid_i(out_valid_i), .out_last_i(out_last_i), .pin_drive_o(pin_drive_o),
  .tx_fifo_flush_request_o(tx_fifo_flush_request_o),
  .rx_fifo_flush_request_o(rx_fifo_flush_request_o));
`default_nettype wire

// *** dv/hsgr_host_model.sv ***
// Host model issuing control-in and control-out reports
`timescale 1ns/1ps
`default_nettype none
module hsgr_host_model (
  // Clock
  input  wire logic  clk_i,
  // Control-in side
  output logic       in_req_o,
  output logic [7:0] in_id_o,
  output logic       in_ready_o,
  input  wire logic  in_valid_i,
  input  wire logic  in_last_i,
  // Control-out side
  output logic       out_valid_o,
  output logic [7:0] out_data_o,
  output logic       out_last_o
);
  // Idle at time zero
  initial {in_req_o, in_id_o, in_ready_o, out_valid_o, out_data_o, out_last_o} = '0;
  // Request one report, accept bytes promptly or every other cycle
  task automatic get(input logic [7:0] id, input bit slow, output bit ok);
    int k;
    ok = 1'b0;
    in_req_o = 1'b1;
    in_id_o = id;
    @(posedge clk_i);
    #1;
    in_req_o = 1'b0;
    in_id_o = ~id;
    for (k = 0; k < 40 && !ok; k++) begin
      in_ready_o = slow ? k[0] : 1'b1;
      @(posedge clk_i);
      ok = in_valid_i && in_ready_o && in_last_i;
      #1;
    end
    in_ready_o = 1'b0;
  endtask
  // code byte first, words upper byte first
  task automatic send(input logic [39:0] b, input int n);
    int i;
    for (i = 0; i < n; i++) begin
      out_valid_o = 1'b1;
      out_data_o = b[39-8*i -: 8];
      out_last_o = (i == n - 1);
      @(posedge clk_i);
      #1;
    end
    out_valid_o = 1'b0;
    out_last_o = 1'b0;
    out_data_o = ~out_data_o;
  endtask
endmodule
`default_nettype wire

// *** dv/test_hid_uart_status_gpio_reports.sv ***
// Self-checking bench for the status, flush and pin report engine
`timescale 1ns/1ps
`default_nettype none
module test_hid_uart_status_gpio_reports;
  logic        clk_i, rst_b_i, in_req_i, in_busy_o, in_nak_o, in_valid_o, in_last_o;
  logic        in_ready_i, out_valid_i, out_last_i, out_nak_o, break_active_i;
  logic        tx_fifo_flush_request_o, rx_fifo_flush_request_o, tx_pin_level_i;
  logic        parity_err_i, overrun_err_i, framing_err_i, break_seen_i, rx_pin_level_i;
  logic        usb_state_pin_one_i, usb_state_pin_two_i;
  logic [7:0]  in_id_i, in_data_o, out_data_i;
  logic [9:0]  tx_fill_i, rx_fill_i, gpio_level_i;
  logic [15:0] pin_is_output_i, pin_drive_o, rnd, drv_e, word;
  logic [7:0]  exp_q[$];
  int          err_total, cmp_count, in_nak_n, out_nak_n, txf_n, rxf_n;
  bit          ok;
  // ----------------------------------------
  // Design, host model and clock
  // ----------------------------------------
  hsgr_top dut_u (.clk_i, .rst_b_i, .in_req_i, .in_id_i, .in_busy_o, .in_nak_o, .in_valid_o,
    .in_data_o, .in_last_o, .in_ready_i, .out_valid_i, .out_data_i, .out_last_i, .out_nak_o,
    .tx_fill_i, .rx_fill_i, .tx_fifo_flush_request_o, .rx_fifo_flush_request_o, .parity_err_i,
    .overrun_err_i, .framing_err_i, .break_seen_i, .break_active_i, .gpio_level_i,
    .tx_pin_level_i, .rx_pin_level_i, .usb_state_pin_one_i, .usb_state_pin_two_i,
    .pin_is_output_i, .pin_drive_o);
  hsgr_host_model host_u (.clk_i(clk_i), .in_req_o(in_req_i), .in_id_o(in_id_i),
    .in_ready_o(in_ready_i), .in_valid_i(in_valid_o), .in_last_i(in_last_o),
    .out_valid_o(out_valid_i), .out_data_o(out_data_i), .out_last_o(out_last_i));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    chk_word(nm, {8'h00, e}, {8'h00, g});
  endtask
  task automatic chk_ok(input string nm);
    chk_word(nm, 16'h0001, {15'h0000, ok});
    if (!ok) test_done();
  endtask
  task automatic test_done();
    $display("Counts: %0d compared, %0d mismatched", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Oldest noted byte against each accepted byte; strobes counted
  always @(posedge clk_i) begin
    if (rst_b_i) begin
      if (in_valid_o && in_ready_i) begin
        chk_byte("in byte", exp_q.size() ? exp_q.pop_front() : 8'hxx, in_data_o);
      end
      in_nak_n += in_nak_o;
      out_nak_n += out_nak_o;
      txf_n += tx_fifo_flush_request_o;
      rxf_n += rx_fifo_flush_request_o;
    end
  end
  // Status read with events one edge before and at the request edge
  task automatic status(input logic [3:0] pre, input logic [3:0] at, input logic [3:0] fl);
    {break_seen_i, framing_err_i, overrun_err_i, parity_err_i} = pre;
    @(posedge clk_i);
    #1;
    {break_seen_i, framing_err_i, overrun_err_i, parity_err_i} = at;
    exp_q.push_back(8'h42);
    exp_q.push_back({6'h00, tx_fill_i[9:8]});
    exp_q.push_back(tx_fill_i[7:0]);
    exp_q.push_back({6'h00, rx_fill_i[9:8]});
    exp_q.push_back(rx_fill_i[7:0]);
    exp_q.push_back({4'h0, fl});
    exp_q.push_back({7'h00, break_active_i});
    fork
      host_u.get(hsgr_pkg::ID_UART_STATUS, rnd[0], ok);
      begin
        @(posedge clk_i);
        #1;
        {break_seen_i, framing_err_i, overrun_err_i, parity_err_i} = 4'h0;
      end
    join
    chk_ok("status done");
    $display("status test done");
  endtask
  // Flush with a given selection and length
  task automatic flush(input logic [7:0] sel, input int n);
    int t;
    int r;
    t = txf_n;
    r = rxf_n;
    host_u.send({hsgr_pkg::ID_FIFO_FLUSH, sel, 24'h000000}, n);
    repeat (2) @(posedge clk_i);
    #1;
    chk_word("tx flush", {15'h0000, sel[0] && n == 2}, 16'(txf_n - t));
    chk_word("rx flush", {15'h0000, sel[1] && n == 2}, 16'(rxf_n - r));
  endtask
  // Pin query, then a masked update with random direction
  task automatic pins();
    {gpio_level_i, tx_pin_level_i, rx_pin_level_i, usb_state_pin_one_i,
      usb_state_pin_two_i} = rnd[13:0];
    word = {1'b0, usb_state_pin_one_i, gpio_level_i[9:6], 1'b0, usb_state_pin_two_i,
      gpio_level_i[5:4], rx_pin_level_i, tx_pin_level_i, gpio_level_i[3:0]};
    exp_q.push_back(8'h44);
    exp_q.push_back(word[15:8]);
    exp_q.push_back(word[7:0]);
    host_u.get(hsgr_pkg::ID_PIN_GET, rnd[1], ok);
    chk_ok("pin query done");
    rnd = lfsr(rnd);
    // Reserved bits claim output and mask; they must stay undriven
    pin_is_output_i = rnd | 16'h8200;
    word = lfsr(rnd) | 16'h8200;
    rnd = lfsr(lfsr(rnd));
    host_u.send({hsgr_pkg::ID_PIN_SET, rnd | 16'h8200, word}, 5);
    word = word & pin_is_output_i & 16'h7dff;
    drv_e = (drv_e & ~word) | (rnd & word);
    @(posedge clk_i);
    #1;
    chk_word("pin drive", drv_e, pin_drive_o);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst_b_i, tx_fill_i, rx_fill_i, break_active_i, gpio_level_i, pin_is_output_i} = '0;
    {parity_err_i, overrun_err_i, framing_err_i, break_seen_i} = 4'h0;
    {tx_pin_level_i, rx_pin_level_i, usb_state_pin_one_i, usb_state_pin_two_i} = 4'h0;
    {rnd, drv_e} = {16'h0008, 16'h0000};
    repeat (5) @(posedge clk_i);
    #1;
    rst_b_i = 1'b1;
    tx_fill_i = 10'h200;
    rx_fill_i = {1'b0, rnd[8:0]};
    break_active_i = 1'b1;
    status(4'hc, 4'h1, 4'hc);
    rnd = lfsr(rnd);
    tx_fill_i = {1'b0, rnd[8:0]};
    rx_fill_i = 10'h200;
    break_active_i = 1'b0;
    status(4'h2, 4'h0, 4'h3);
    status(4'h0, 4'h0, 4'h0);
    for (int s = 0; s < 4; s++) flush(8'(s), 2);
    flush(8'h03, 3);
    chk_word("out nak count", 16'h0001, 16'(out_nak_n));
    $display("flush test done");
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      pins();
    end
    $display("pin test done");
    // Mid-run reset returns the pin drive to idle
    rst_b_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    chk_word("pin drive reset", 16'h0000, pin_drive_o);
    rst_b_i = 1'b1;
    drv_e = 16'h0000;
    $display("reset test done");
    host_u.get(8'h46, 1'b0, ok);
    chk_word("nak no report", 16'h0000, {15'h0000, ok});
    chk_word("in nak count", 16'h0001, 16'(in_nak_n));
    $display("unknown code test done");
    test_done();
  end
endmodule
`default_nettype wire
